// file: hw/perr_pkg.sv
// Function
// - mask bit 0 resets to 0; when set, receiver faults are not reported upstream.
// - mask bits 6 and 7 hide corrupt packet and corrupt link packet; reset 0.
// - mask bits 8 and 12 hide replay count wrap and replay timer expiry; reset 0.
// - mask bit 13 hides advisory nonfatal and resets to 1.
// - any set mask bit suppresses that event's upstream report, whatever its status.
// - control bits 4:0 hold a read-only sticky index of the first uncorrectable error.
// - control bit 5 says CRC generation is possible; locked, reads 1 after reset.
// - control bit 6 is a sticky enable, reset 0, that turns CRC generation on.
// - control bit 7 says CRC checking is possible; locked, reads 1 after reset.
// - control bit 8 is a sticky enable, reset 0, that turns CRC checking on.
// - four sticky read-only words log the header of the first uncorrectable error.
// - status bit 0 sets on a receiver fault; status bits are sticky, write one clears.
package perr_pkg;

  // ==========================================================================
  // address map
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_COR_STATUS = 12'h110;
  localparam logic [11:0] OFF_COR_MASK = 12'h114;
  localparam logic [11:0] OFF_ERR_CTL = 12'h118;
  localparam logic [11:0] OFF_HDR_LOG0 = 12'h11C;
  localparam logic [11:0] OFF_HDR_LOG1 = 12'h120;
  localparam logic [11:0] OFF_HDR_LOG2 = 12'h124;
  localparam logic [11:0] OFF_HDR_LOG3 = 12'h128;
  localparam logic [11:0] OFF_UNC_STATUS = 12'h140;

  // ==========================================================================
  // field layout and reset values
  localparam logic [31:0] COR_IMPL_MASK = 32'h000031C1;
  localparam logic [31:0] UNC_IMPL_MASK = 32'h001F3FFF;
  localparam logic [31:0] COR_MASK_RESET = 32'h00002000;
  localparam int CTL_FEP_LSB = 0;
  localparam int CTL_GEN_CAP = 5;
  localparam int CTL_GEN_EN = 6;
  localparam int CTL_CHK_CAP = 7;
  localparam int CTL_CHK_EN = 8;
  localparam logic CAP_RESET = 1'b1;
  localparam logic EN_RESET = 1'b0;
  localparam logic [4:0] FEP_RESET = 5'h00;
  localparam logic [31:0] HDR_RESET = 32'h00000000;

  // ==========================================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [31:0] word3;
    logic [31:0] word2;
    logic [31:0] word1;
    logic [31:0] word0;
  } perr_hdr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } perr_wreq_t;

endpackage : perr_pkg

// file: hw/perr_sticky_bank.sv
`timescale 1ns/1ps
module perr_sticky_bank
  import perr_pkg::*;
#(
  parameter int W = 32,
  parameter logic [31:0] IMPL = 32'hFFFFFFFF
)
(
  // clock and fundamental reset
  input wire logic aclk,
  input wire logic aresetn,
  // events and write-one clears
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // status
  output logic [W-1:0] status_o
);

  // ==========================================================================
  // one flag per bit, set has priority so a clear never loses a new event
  logic [W-1:0] status_reg;
  wire logic [W-1:0] status_next;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      if (IMPL[i])
      begin : g_impl
        assign status_next[i] = set_i[i] || (status_reg[i] && !clr_i[i]);
      end
      else
      begin : g_rsvd
        assign status_next[i] = 1'b0;
      end
    end
  endgenerate

  // one register for the whole vector, so no bit has two kinds of driver
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  assign status_o = status_reg;

endmodule : perr_sticky_bank

// file: hw/perr_axil_slave.sv
`timescale 1ns/1ps
module perr_axil_slave
  import perr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [perr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [perr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  output perr_pkg::perr_wreq_t wr_req,
  output logic wr_en,
  input wire logic wr_hit,
  output logic [perr_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  logic aw_held_reg;
  logic w_held_reg;
  perr_wreq_t req_reg;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_req = req_reg;
  // no write commits while a response is still waiting
  assign wr_en = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  // ==========================================================================
  // write address and data captured independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      req_reg <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        req_reg.addr <= s_axi_awaddr;
      end
      else if (wr_en)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        req_reg.data <= s_axi_wdata;
        req_reg.strb <= s_axi_wstrb;
      end
      else if (wr_en)
        w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================================
  // read answered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_data : 32'h00000000;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : perr_axil_slave

// file: hw/perr_error_report_regs.sv
`timescale 1ns/1ps
module perr_error_report_regs
  import perr_pkg::*;
(
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hot_reset_n,
  // axi4-lite write
  input wire logic [perr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [perr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // error events from the port
  input wire logic [31:0] cor_event,
  input wire logic [31:0] unc_event,
  input wire perr_pkg::perr_hdr_t unc_header,
  input wire logic cap_unlock,
  // controls and report
  output logic crc_gen_on,
  output logic crc_check_on,
  output logic cor_report_irq
);

  // ==========================================================================
  // bus front end
  perr_wreq_t wr_req;
  logic wr_en;
  logic wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;

  perr_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_req(wr_req),
    .wr_en(wr_en),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ==========================================================================
  // write decode and byte lanes
  logic sel_cor_status;
  logic sel_cor_mask;
  logic sel_ctl;
  logic sel_unc_status;
  logic [31:0] wmask;

  assign sel_cor_status = wr_en && (wr_req.addr == OFF_COR_STATUS);
  assign sel_cor_mask = wr_en && (wr_req.addr == OFF_COR_MASK);
  assign sel_ctl = wr_en && (wr_req.addr == OFF_ERR_CTL);
  assign sel_unc_status = wr_en && (wr_req.addr == OFF_UNC_STATUS);
  // log words are read-only but mapped, so a write to them still answers okay
  assign wr_hit = (wr_req.addr == OFF_COR_STATUS) || (wr_req.addr == OFF_COR_MASK)
    || (wr_req.addr == OFF_ERR_CTL) || (wr_req.addr == OFF_UNC_STATUS)
    || (wr_req.addr == OFF_HDR_LOG0) || (wr_req.addr == OFF_HDR_LOG1)
    || (wr_req.addr == OFF_HDR_LOG2) || (wr_req.addr == OFF_HDR_LOG3);
  assign wmask = {{8{wr_req.strb[3]}}, {8{wr_req.strb[2]}}, {8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};

  // ==========================================================================
  // correctable and uncorrectable status, write one to clear
  logic [31:0] cor_status;
  logic [31:0] cor_clr;
  logic [31:0] unc_status;
  logic [31:0] unc_clr;

  assign cor_clr = sel_cor_status ? (wr_req.data & wmask) : 32'h00000000;
  assign unc_clr = sel_unc_status ? (wr_req.data & wmask) : 32'h00000000;

  perr_sticky_bank #(
    .W(32),
    .IMPL(COR_IMPL_MASK)
  ) u_cor_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_i(cor_event),
    .clr_i(cor_clr),
    .status_o(cor_status)
  );

  perr_sticky_bank #(
    .W(32),
    .IMPL(UNC_IMPL_MASK)
  ) u_unc_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_i(unc_event),
    .clr_i(unc_clr),
    .status_o(unc_status)
  );

  // ==========================================================================
  // correctable mask, sticky, reserved bits forced to zero
  logic [31:0] cor_mask_reg;
  logic [31:0] cor_mask_next;

  assign cor_mask_next = ((cor_mask_reg & ~wmask) | (wr_req.data & wmask)) & COR_IMPL_MASK;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cor_mask_reg <= COR_MASK_RESET;
    else if (sel_cor_mask)
      cor_mask_reg <= cor_mask_next;
  end

  // ==========================================================================
  // upstream report; registered so it is a clean level
  logic cor_report_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cor_report_reg <= 1'b0;
    else
      cor_report_reg <= |(cor_status & ~cor_mask_reg);
  end

  assign cor_report_irq = cor_report_reg;

  // ==========================================================================
  // crc capability bits: not sticky, writable only while unlocked
  logic gen_cap_reg;
  logic chk_cap_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !hot_reset_n)
    begin
      gen_cap_reg <= CAP_RESET;
      chk_cap_reg <= CAP_RESET;
    end
    else if (sel_ctl && cap_unlock && wr_req.strb[0])
    begin
      gen_cap_reg <= wr_req.data[CTL_GEN_CAP];
      chk_cap_reg <= wr_req.data[CTL_CHK_CAP];
    end
  end

  // ==========================================================================
  // crc enables: sticky, so only the fundamental reset clears them
  logic gen_en_reg;
  logic chk_en_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gen_en_reg <= EN_RESET;
      chk_en_reg <= EN_RESET;
    end
    else if (sel_ctl)
    begin
      if (wr_req.strb[0])
        gen_en_reg <= wr_req.data[CTL_GEN_EN];
      if (wr_req.strb[1])
        chk_en_reg <= wr_req.data[CTL_CHK_EN];
    end
  end

  assign crc_gen_on = gen_en_reg;
  assign crc_check_on = chk_en_reg;

  // ==========================================================================
  // first error capture
  logic [4:0] fep_reg;
  logic log_valid_reg;
  perr_hdr_t hdr_log_reg;
  logic [31:0] unc_set;
  logic locked;
  logic capture;
  logic [4:0] first_index;

  function automatic logic [4:0] lowest_index(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int k = 31; k >= 0; k--)
    begin
      if (v[k])
        idx = k[4:0];
    end
    return idx;
  endfunction : lowest_index

  assign unc_set = unc_event & UNC_IMPL_MASK;
  // held while the pointed status bit is still set
  assign locked = log_valid_reg && unc_status[fep_reg];
  assign capture = (|unc_set) && !locked;
  assign first_index = lowest_index(unc_set);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fep_reg <= FEP_RESET;
      log_valid_reg <= 1'b0;
    end
    else if (capture)
    begin
      fep_reg <= first_index;
      log_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hdr_log_reg <= {HDR_RESET, HDR_RESET, HDR_RESET, HDR_RESET};
    else if (capture)
      hdr_log_reg <= unc_header;
  end

  // ==========================================================================
  // read mux; reserved bits read as zero
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (rd_addr)
      OFF_COR_STATUS: rd_data = cor_status;
      OFF_COR_MASK: rd_data = cor_mask_reg;
      OFF_ERR_CTL:
      begin
        rd_data[CTL_FEP_LSB +: 5] = fep_reg;
        rd_data[CTL_GEN_CAP] = gen_cap_reg;
        rd_data[CTL_GEN_EN] = gen_en_reg;
        rd_data[CTL_CHK_CAP] = chk_cap_reg;
        rd_data[CTL_CHK_EN] = chk_en_reg;
      end
      OFF_HDR_LOG0: rd_data = hdr_log_reg.word0;
      OFF_HDR_LOG1: rd_data = hdr_log_reg.word1;
      OFF_HDR_LOG2: rd_data = hdr_log_reg.word2;
      OFF_HDR_LOG3: rd_data = hdr_log_reg.word3;
      OFF_UNC_STATUS: rd_data = unc_status;
      default: rd_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // checks
  property p_rcv_masked;
    @(posedge aclk) disable iff (!aresetn)
    (cor_mask_reg[0] && cor_status == 32'h00000001) |=> !cor_report_irq;
  endproperty
  a_rcv_masked: assert property (p_rcv_masked)
    else $error("masked receiver fault was reported");

  property p_bad_pkt_report;
    @(posedge aclk) disable iff (!aresetn)
    (cor_status[6] && !cor_mask_reg[6]) |=> cor_report_irq;
  endproperty
  a_bad_pkt_report: assert property (p_bad_pkt_report)
    else $error("unmasked corrupt packet not reported");

  property p_mask_reset;
    @(posedge aclk)
    !aresetn |=> (cor_mask_reg[8] == 1'b0) && (cor_mask_reg[12] == 1'b0) && (cor_mask_reg[7:6] == 2'h0);
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("replay mask bits not zero after reset");

  property p_advisory_reset;
    @(posedge aclk)
    !aresetn |=> cor_mask_reg == 32'h00002000;
  endproperty
  a_advisory_reset: assert property (p_advisory_reset)
    else $error("mask reset value wrong");

  property p_all_masked_quiet;
    @(posedge aclk) disable iff (!aresetn)
    ((cor_status & ~cor_mask_reg) == 32'h00000000)[*2] |-> !cor_report_irq;
  endproperty
  a_all_masked_quiet: assert property (p_all_masked_quiet)
    else $error("report raised with every status masked");

  property p_fep_capture;
    @(posedge aclk) disable iff (!aresetn)
    (capture && unc_event[3] && unc_event[2:0] == 3'h0) |=> fep_reg == 5'h03;
  endproperty
  a_fep_capture: assert property (p_fep_capture)
    else $error("first error index not captured");

  property p_cap_reset;
    @(posedge aclk)
    !aresetn |=> gen_cap_reg && chk_cap_reg;
  endproperty
  a_cap_reset: assert property (p_cap_reset)
    else $error("capability bits not one after reset");

  property p_gen_enable;
    @(posedge aclk) disable iff (!aresetn)
    (sel_ctl && wr_req.strb[0] && wr_req.data[6]) |=> crc_gen_on;
  endproperty
  a_gen_enable: assert property (p_gen_enable)
    else $error("crc generation enable did not take");

  property p_chk_enable;
    @(posedge aclk) disable iff (!aresetn)
    (sel_ctl && wr_req.strb[1]) |=> crc_check_on == $past(wr_req.data[8]);
  endproperty
  a_chk_enable: assert property (p_chk_enable)
    else $error("crc check enable did not follow write");

  property p_hdr_capture;
    @(posedge aclk) disable iff (!aresetn)
    capture |=> hdr_log_reg == $past(unc_header);
  endproperty
  a_hdr_capture: assert property (p_hdr_capture)
    else $error("header log not captured");

  property p_rcv_status;
    @(posedge aclk) disable iff (!aresetn)
    cor_event[0] |=> cor_status[0];
  endproperty
  a_rcv_status: assert property (p_rcv_status)
    else $error("receiver fault status not set");

  property p_sticky_hot;
    @(posedge aclk) disable iff (!aresetn)
    (!hot_reset_n && !sel_cor_mask && !sel_ctl) |=> $stable(cor_mask_reg) && $stable(gen_en_reg);
  endproperty
  a_sticky_hot: assert property (p_sticky_hot)
    else $error("sticky field changed on hot reset");

  property p_log_frozen;
    @(posedge aclk) disable iff (!aresetn)
    locked |=> $stable(fep_reg) && $stable(hdr_log_reg);
  endproperty
  a_log_frozen: assert property (p_log_frozen)
    else $error("first error log overwritten while held");

endmodule : perr_error_report_regs

// file: testbench/perr_event_src.sv
`timescale 1ns/1ps
// ============================================================
// error event source standing in for the port logic
module perr_event_src
  import perr_pkg::*;
(
  // clock
  input wire logic aclk,
  // events towards the register group
  output logic [31:0] cor_event,
  output logic [31:0] unc_event,
  output perr_pkg::perr_hdr_t unc_header
);
  initial
  begin
    cor_event = 32'h0;
    unc_event = 32'h0;
    unc_header = '0;
  end

  // one-cycle pulse; the header is only valid in the event cycle,
  // afterwards it shows the inverse so a late sample cannot pass
  task automatic fire(input logic [31:0] c, input logic [31:0] u, input perr_hdr_t h);
    @(posedge aclk);
    cor_event <= c;
    unc_event <= u;
    unc_header <= h;
    @(posedge aclk);
    cor_event <= 32'h0;
    unc_event <= 32'h0;
    unc_header <= ~h;
  endtask : fire
endmodule : perr_event_src

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import perr_pkg::*;
  logic aclk, aresetn, hot_reset_n, cap_unlock;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, ce, ue;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  perr_hdr_t hdr;
  logic gen_on, chk_on, irq;
  int num_errors, checks_done;
  logic [31:0] seed, m_mask, m_cs, m_us;
  logic [127:0] m_hdr;
  logic [4:0] m_fep;
  logic m_ge, m_ce, m_gc, m_cc;

  perr_error_report_regs i_dut (.aclk(aclk), .aresetn(aresetn), .hot_reset_n(hot_reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cor_event(ce), .unc_event(ue), .unc_header(hdr), .cap_unlock(cap_unlock),
    .crc_gen_on(gen_on), .crc_check_on(chk_on), .cor_report_irq(irq));

  perr_event_src i_src (.aclk(aclk), .cor_event(ce), .unc_event(ue), .unc_header(hdr));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ============================================================
  // checking helpers
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n > 60)
    begin
      num_errors++;
      $display("unexpected at %0t: no answer", $time);
      finish_test();
    end
  endtask : tmo

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // ============================================================
  // reference model
  function automatic bit mp(input logic [11:0] a);
    return (a >= OFF_COR_STATUS && a <= OFF_HDR_LOG3 && a[1:0] == 2'h0) || a == OFF_UNC_STATUS;
  endfunction : mp

  function automatic logic [31:0] expv(input logic [11:0] a);
    case (a)
      OFF_COR_STATUS: return m_cs;
      OFF_COR_MASK: return m_mask;
      OFF_ERR_CTL: return {23'h0, m_ce, m_cc, m_ge, m_gc, m_fep};
      OFF_HDR_LOG0, OFF_HDR_LOG1, OFF_HDR_LOG2, OFF_HDR_LOG3: return m_hdr[(a - OFF_HDR_LOG0) * 8 +: 32];
      OFF_UNC_STATUS: return m_us;
      default: return 32'h0;
    endcase
  endfunction : expv

  // ============================================================
  // bus master
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ad;
    logic dd;
    logic [31:0] m;
    n = 0;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      ad = ad | awready;
      dd = dd | wready;
      awvalid <= !ad;
      wvalid <= !dd;
      n++;
      tmo(n);
    end
    do
    begin
      @(posedge aclk);
      n++;
      tmo(n);
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, mp(a) ? RESP_OKAY : RESP_SLVERR});
    // only strobed byte lanes may change
    m = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    case (a)
      OFF_COR_MASK: m_mask = ((m_mask & ~m) | (d & m)) & COR_IMPL_MASK;
      OFF_ERR_CTL: {m_ce, m_cc, m_ge, m_gc} = {m[8] ? d[8] : m_ce, (cap_unlock && m[0]) ? d[7] : m_cc,
        m[0] ? d[6] : m_ge, (cap_unlock && m[0]) ? d[5] : m_gc};
      OFF_COR_STATUS: m_cs = m_cs & ~(d & m);
      OFF_UNC_STATUS: m_us = m_us & ~(d & m);
      default: ;
    endcase
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int n;
    logic [31:0] e;
    n = 0;
    e = expv(a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      arvalid <= arvalid && !arready;
      n++;
      tmo(n);
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, mp(a) ? RESP_OKAY : RESP_SLVERR});
    @(posedge aclk);
  endtask : rd

  // 0x12C is the unmapped word just past the header log
  task automatic sweep();
    for (int i = 0; i < 8; i++)
      rd(12'h110 + 12'(4 * i));
    rd(OFF_UNC_STATUS);
    chk({30'h0, gen_on, chk_on}, {30'h0, m_ge, m_ce});
  endtask : sweep

  task automatic ev(input logic [31:0] c, input logic [31:0] u, input perr_hdr_t h);
    i_src.fire(c, u, h);
    if (!m_us[m_fep] && (u & UNC_IMPL_MASK) != 32'h0)
    begin
      for (int i = 31; i >= 0; i--)
        if (u[i] & UNC_IMPL_MASK[i]) m_fep = 5'(i);
      m_hdr = h;
    end
    m_us = m_us | (u & UNC_IMPL_MASK);
    m_cs = m_cs | (c & COR_IMPL_MASK);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, |(m_cs & ~m_mask)});
  endtask : ev

  // a hot reset only brings the capability bits back
  task automatic rst(input bit hot);
    if (hot) hot_reset_n <= 1'b0;
    else aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    hot_reset_n <= 1'b1;
    aresetn <= 1'b1;
    m_gc = CAP_RESET;
    m_cc = CAP_RESET;
    if (!hot)
    begin
      {m_mask, m_cs, m_us, m_hdr} = {COR_MASK_RESET, 64'h0, 128'h0};
      {m_fep, m_ge, m_ce} = {FEP_RESET, EN_RESET, EN_RESET};
    end
    @(posedge aclk);
  endtask : rst

  // ============================================================
  // main sequence
  initial
  begin
    {aresetn, hot_reset_n, cap_unlock} = 3'b010;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
    num_errors = 0;
    checks_done = 0;
    seed = 32'h464E;
    rst(1'b0);
    sweep();
    wr(OFF_COR_MASK, 32'hFFFFFFFF);
    wr(OFF_ERR_CTL, 32'hFFFFFFFF);
    wr(OFF_HDR_LOG2, rnd());
    wr(12'h200, rnd());
    sweep();
    for (int i = 0; i < 24; i++)
    begin
      wstrb <= 4'(rnd());
      wr(OFF_COR_MASK, rnd());
      ev(rnd() & rnd() & COR_IMPL_MASK, 32'h0, '0);
      rd(OFF_COR_STATUS);
      wr(OFF_COR_STATUS, rnd());
    end
    wstrb <= 4'hF;
    for (int i = 0; i < 8; i++)
    begin
      ev(32'h0, rnd() & rnd() & UNC_IMPL_MASK, {rnd(), rnd(), rnd(), rnd()});
      sweep();
      if (i[0]) wr(OFF_UNC_STATUS, 32'h1 << m_fep);
    end
    cap_unlock <= 1'b1;
    wr(OFF_ERR_CTL, 32'h00000140);
    cap_unlock <= 1'b0;
    sweep();
    rst(1'b1);
    sweep();
    rst(1'b0);
    sweep();
    finish_test();
  end
endmodule : tb_top
